// >>> rtl/pms_phy_mode_regs.sv
// PHY energy-detect and special-modes management registers with mode decode
//
// Contract
// - Bit 13 enables energy-detect power-down, resets 0
// - Energy bit set on energy, clears after 256ms
// - Energy bit survives soft reset, hard reset sets
// - Loader rewrites special modes after reset, reload
// - Bits 7:5 hold operating mode selection
// - Bits 4:0 hold management address
// - Management address seeds scrambler key
// - Kept bits reset by port reset, not soft
// - Autoneg strap set gives mode 111
// - Else mode is 0, speed strap, duplex strap
// - Straps captured when chip reset releases
// - Address default comes from address strap
// - Mode 000 forces 10 half, bits 0000
// - Mode 001 forces 10 full, bits 0001
// - Mode 010 forces 100 half, CRS tx+rx
// - Mode 011 forces 100 full, CRS rx
// - Mode 100 negotiates 100 half, 1100/0100
// - Mode 101 repeater, like 100, CRS rx
// - Mode 110 power-down, registers untouched
// - Mode 111 all abilities, X10X/1111
`timescale 1ns/1ps
`default_nettype none
module pms_phy_mode_regs #(
  parameter int TIMEOUT_CYC = pms_pkg::ENERGY_TIMEOUT_CYC
) (
  // Clock and chip reset
  input wire logic CLK,
  input wire logic RST_B,
  // Port PHY reset from chip reset control register, and basic-control soft reset
  input wire logic PORT_PHY_RST,
  input wire logic SOFT_RST,
  // Configuration strap pins
  input wire logic AUTONEG_STRAP,
  input wire logic SPEED_STRAP,
  input wire logic DUPLEX_STRAP,
  input wire logic [4:0] ADDR_STRAP,
  // Line energy detector
  input wire logic ENERGY_SEEN,
  // Management register access
  input wire pms_pkg::pms_mgmt_req_t MGMT_REQ,
  output logic [15:0] MGMT_RDATA,
  // EEPROM loader rewrite of special modes
  input wire logic LOAD_WR,
  input wire logic [15:0] LOAD_DATA,
  // Settings to the rest of the PHY
  output logic ENERGY_DETECT_POWERDOWN_EN,
  output logic [4:0] PHY_MGMT_ADDRESS,
  output logic [4:0] SCRAMBLER_SEED,
  output pms_pkg::pms_mode_cfg_t MODE_CFG
);
  localparam int CW = $clog2(TIMEOUT_CYC + 1);

  // Elaboration check: the quiet counter needs at least two states
  if (TIMEOUT_CYC < 2) begin : g_bad_timeout
    $error("TIMEOUT_CYC too small");
  end

  // Mode code to settings decode
  function automatic pms_pkg::pms_mode_cfg_t decode_mode(input logic [2:0] m);
    pms_pkg::pms_mode_cfg_t c;
    c = '0;
    case (m)
      pms_pkg::MODE_10HD: begin
        c.bc_we = 1'b1;
        c.bc = pms_pkg::BC_10HD;
      end
      pms_pkg::MODE_10FD: begin
        c.bc_we = 1'b1;
        c.bc = pms_pkg::BC_10FD;
      end
      pms_pkg::MODE_100HD: begin
        c.bc_we = 1'b1;
        c.bc = pms_pkg::BC_100HD;
        c.crs_tx = 1'b1;
      end
      pms_pkg::MODE_100FD: begin
        c.bc_we = 1'b1;
        c.bc = pms_pkg::BC_100FD;
      end
      pms_pkg::MODE_AN_100HD: begin
        c.bc_we = 1'b1;
        c.bc = pms_pkg::BC_AN_100HD;
        c.adv_we = 1'b1;
        c.adv = pms_pkg::ADV_100HD;
        c.crs_tx = 1'b1;
      end
      pms_pkg::MODE_REPEATER: begin
        c.bc_we = 1'b1;
        c.bc = pms_pkg::BC_AN_100HD;
        c.adv_we = 1'b1;
        c.adv = pms_pkg::ADV_100HD;
        c.repeater = 1'b1;
      end
      pms_pkg::MODE_POWERDOWN: begin
        c.powerdown = 1'b1;
      end
      default: begin
        c.bc_we = 1'b1;
        c.bc = pms_pkg::BC_AN_100HD;
        c.bc_keep_sd = 1'b1;
        c.adv_we = 1'b1;
        c.adv = pms_pkg::ADV_ALL;
        c.crs_tx = 1'b1;
      end
    endcase
    return c;
  endfunction : decode_mode

  // Strap default mode
  function automatic logic [2:0] strap_mode(input logic an, input logic sp, input logic dx);
    return an ? pms_pkg::MODE_ALL : {1'b0, sp, dx};
  endfunction : strap_mode

  // Pin synchronisers
  logic [1:0] an_sync, sp_sync, dx_sync, en_sync;
  logic [4:0] addr_s1, addr_s2;
  logic [1:0] prst_sync, srst_sync;

  // Two-stage capture of pin inputs
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      an_sync <= 2'h0;
      sp_sync <= 2'h0;
      dx_sync <= 2'h0;
      en_sync <= 2'h0;
      addr_s1 <= 5'h00;
      addr_s2 <= 5'h00;
      prst_sync <= 2'h0;
      srst_sync <= 2'h0;
    end else begin
      an_sync <= {an_sync[0], AUTONEG_STRAP};
      sp_sync <= {sp_sync[0], SPEED_STRAP};
      dx_sync <= {dx_sync[0], DUPLEX_STRAP};
      en_sync <= {en_sync[0], ENERGY_SEEN};
      addr_s1 <= ADDR_STRAP;
      addr_s2 <= addr_s1;
      prst_sync <= {prst_sync[0], PORT_PHY_RST};
      srst_sync <= {srst_sync[0], SOFT_RST};
    end
  end

  // Strap latch state: both synchroniser stages must fill before capture
  typedef enum logic [3:0] {
    ST_SYNC = 4'b0001,
    ST_FILL0 = 4'b0010,
    ST_FILL1 = 4'b0100,
    ST_RUN = 4'b1000
  } pms_state_t;

  pms_state_t state, next_state;
  logic [2:0] strap_mode_q, next_strap_mode_q;
  logic [4:0] strap_addr, next_strap_addr;
  logic edpd, next_edpd;
  logic energy, next_energy;
  logic [CW-1:0] quiet_cnt, next_quiet_cnt;
  logic [2:0] mode, next_mode;
  logic [4:0] addr, next_addr;
  logic rsvd0, next_rsvd0;
  logic port_rst;
  logic wr_edpd, wr_special;

  assign port_rst = prst_sync[1];
  assign wr_edpd = MGMT_REQ.wr && (MGMT_REQ.reg_addr == pms_pkg::REG_ENERGY_PD);
  assign wr_special = MGMT_REQ.wr && (MGMT_REQ.reg_addr == pms_pkg::REG_SPECIAL);

  // Next-state logic for all register state
  always_comb begin
    next_state = state;
    next_strap_mode_q = strap_mode_q;
    next_strap_addr = strap_addr;
    next_edpd = edpd;
    next_energy = energy;
    next_quiet_cnt = quiet_cnt;
    next_mode = mode;
    next_addr = addr;
    next_rsvd0 = rsvd0;
    case (state)
      ST_SYNC: begin
        // First synchroniser stage takes the pins
        next_state = ST_FILL0;
      end
      ST_FILL0: begin
        next_state = ST_FILL1;
      end
      ST_FILL1: begin
        // Capture straps once, right after chip reset release
        next_state = ST_RUN;
        next_strap_mode_q = strap_mode(an_sync[1], sp_sync[1], dx_sync[1]);
        next_strap_addr = addr_s2;
        next_mode = strap_mode(an_sync[1], sp_sync[1], dx_sync[1]);
        next_addr = addr_s2;
      end
      default: begin
        // Energy indicator: set on energy, clear after quiet period
        if (en_sync[1]) begin
          next_energy = 1'b1;
          next_quiet_cnt = '0;
        end else if (quiet_cnt >= CW'(TIMEOUT_CYC - 1)) begin
          next_energy = 1'b0;
        end else begin
          next_quiet_cnt = quiet_cnt + CW'(1);
        end
        // Host writes
        if (wr_edpd) begin
          next_edpd = MGMT_REQ.wdata[pms_pkg::EDPD_BIT];
          next_rsvd0 = MGMT_REQ.wdata[pms_pkg::RSVD0_BIT];
        end
        if (wr_special) begin
          next_mode = MGMT_REQ.wdata[pms_pkg::MODE_LSB +: 3];
          next_addr = MGMT_REQ.wdata[pms_pkg::ADDR_LSB +: 5];
        end
        // Loader rewrite wins over a host write in the same cycle
        if (LOAD_WR) begin
          next_mode = LOAD_DATA[pms_pkg::MODE_LSB +: 3];
          next_addr = LOAD_DATA[pms_pkg::ADDR_LSB +: 5];
        end
        // Port PHY reset restores defaults; soft reset leaves state alone
        if (port_rst) begin
          next_edpd = pms_pkg::RST_EDPD;
          next_rsvd0 = 1'b0;
          next_mode = strap_mode_q;
          next_addr = strap_addr;
        end
      end
    endcase
  end

  // State registers; energy resets to 1 on hardware reset only
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= ST_SYNC;
      strap_mode_q <= 3'h0;
      strap_addr <= 5'h00;
      edpd <= pms_pkg::RST_EDPD;
      energy <= pms_pkg::RST_ENERGY;
      quiet_cnt <= '0;
      mode <= 3'h0;
      addr <= 5'h00;
      rsvd0 <= 1'b0;
    end else begin
      state <= next_state;
      strap_mode_q <= next_strap_mode_q;
      strap_addr <= next_strap_addr;
      edpd <= next_edpd;
      energy <= next_energy;
      quiet_cnt <= next_quiet_cnt;
      mode <= next_mode;
      addr <= next_addr;
      rsvd0 <= next_rsvd0;
    end
  end

  // Read data and outputs
  logic [15:0] next_rdata;
  always_comb begin
    next_rdata = 16'h0000;
    if (MGMT_REQ.reg_addr == pms_pkg::REG_ENERGY_PD) begin
      next_rdata[pms_pkg::EDPD_BIT] = edpd;
      next_rdata[pms_pkg::ENERGY_BIT] = energy;
      next_rdata[pms_pkg::RSVD0_BIT] = rsvd0;
    end else if (MGMT_REQ.reg_addr == pms_pkg::REG_SPECIAL) begin
      next_rdata[pms_pkg::MODE_LSB +: 3] = mode;
      next_rdata[pms_pkg::ADDR_LSB +: 5] = addr;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      MGMT_RDATA <= 16'h0000;
      MODE_CFG <= '0;
    end else begin
      MGMT_RDATA <= next_rdata;
      MODE_CFG <= decode_mode(mode);
    end
  end

  assign ENERGY_DETECT_POWERDOWN_EN = edpd;
  assign PHY_MGMT_ADDRESS = addr;
  assign SCRAMBLER_SEED = addr;

  // Assertions
  sequence s_port_rst;
    (state == ST_RUN) && port_rst;
  endsequence

  a_edpd_write: assert property (@(posedge CLK) disable iff (!RST_B)
    (state == ST_RUN) && wr_edpd && !port_rst |=> edpd == $past(MGMT_REQ.wdata[13]))
    else $error("edpd not written");
  a_energy_set: assert property (@(posedge CLK) disable iff (!RST_B)
    (state == ST_RUN) && en_sync[1] |=> energy)
    else $error("energy not set");
  a_energy_hold: assert property (@(posedge CLK) disable iff (!RST_B)
    $fell(energy) |-> $past(quiet_cnt) == CW'(TIMEOUT_CYC - 1))
    else $error("energy cleared early");
  a_soft_keep: assert property (@(posedge CLK) disable iff (!RST_B)
    (state == ST_RUN) && srst_sync[1] && !port_rst && !wr_edpd |=> edpd == $past(edpd))
    else $error("soft reset touched state");
  a_loader_mode: assert property (@(posedge CLK) disable iff (!RST_B)
    (state == ST_RUN) && LOAD_WR && !port_rst |=> mode == $past(LOAD_DATA[7:5]))
    else $error("loader mode lost");
  a_special_wr: assert property (@(posedge CLK) disable iff (!RST_B)
    (state == ST_RUN) && wr_special && !LOAD_WR && !port_rst
    |=> addr == $past(MGMT_REQ.wdata[4:0]) && mode == $past(MGMT_REQ.wdata[7:5]))
    else $error("special write lost");
  a_seed_addr: assert property (@(posedge CLK) disable iff (!RST_B)
    SCRAMBLER_SEED == PHY_MGMT_ADDRESS)
    else $error("seed differs");
  a_port_reset: assert property (@(posedge CLK) disable iff (!RST_B)
    s_port_rst |=> !edpd && mode == strap_mode_q && addr == strap_addr)
    else $error("port reset failed");
  a_strap_an: assert property (@(posedge CLK) disable iff (!RST_B)
    (state == ST_FILL1) && an_sync[1] |=> mode == 3'h7)
    else $error("autoneg default wrong");
  a_strap_fix: assert property (@(posedge CLK) disable iff (!RST_B)
    (state == ST_FILL1) && !an_sync[1] |=> mode == {1'b0, $past(sp_sync[1]), $past(dx_sync[1])})
    else $error("forced default wrong");
  a_mode_111: assert property (@(posedge CLK) disable iff (!RST_B)
    mode == 3'h7 |=> MODE_CFG.adv == 4'hF && MODE_CFG.bc[2:1] == 2'b10)
    else $error("mode 111 decode");
  a_mode_010: assert property (@(posedge CLK) disable iff (!RST_B)
    mode == 3'h2 |=> MODE_CFG.bc == 4'h8 && MODE_CFG.crs_tx && !MODE_CFG.adv_we)
    else $error("mode 010 decode");
endmodule : pms_phy_mode_regs
`default_nettype wire

// >>> rtl/pms_pkg.sv
// Package: register indices, field positions, mode codes and timing for the PHY mode block
package pms_pkg;
  // Register indices on the management interface
  localparam logic [4:0] REG_ENERGY_PD = 5'h11;
  localparam logic [4:0] REG_SPECIAL = 5'h12;
  // Field positions
  localparam int EDPD_BIT = 13;
  localparam int ENERGY_BIT = 1;
  localparam int RSVD0_BIT = 0;
  localparam int MODE_LSB = 5;
  localparam int ADDR_LSB = 0;
  // Mode codes
  localparam logic [2:0] MODE_10HD = 3'h0;
  localparam logic [2:0] MODE_10FD = 3'h1;
  localparam logic [2:0] MODE_100HD = 3'h2;
  localparam logic [2:0] MODE_100FD = 3'h3;
  localparam logic [2:0] MODE_AN_100HD = 3'h4;
  localparam logic [2:0] MODE_REPEATER = 3'h5;
  localparam logic [2:0] MODE_POWERDOWN = 3'h6;
  localparam logic [2:0] MODE_ALL = 3'h7;
  // Basic control bits 13,12,10,8 and advertisement bits 8..5 per mode
  localparam logic [3:0] BC_10HD = 4'h0;
  localparam logic [3:0] BC_10FD = 4'h1;
  localparam logic [3:0] BC_100HD = 4'h8;
  localparam logic [3:0] BC_100FD = 4'h9;
  localparam logic [3:0] BC_AN_100HD = 4'hC;
  localparam logic [3:0] ADV_100HD = 4'h4;
  localparam logic [3:0] ADV_ALL = 4'hF;
  // Energy timeout
  localparam int ENERGY_TIMEOUT_MS = 256;
  localparam int CLK_MHZ = 125;
  localparam int ENERGY_TIMEOUT_CYC = ENERGY_TIMEOUT_MS * 1000 * CLK_MHZ;
  // Reset values
  localparam logic RST_EDPD = 1'b0;
  localparam logic RST_ENERGY = 1'b1;

  // Mode-derived settings pushed to the basic control and advertisement registers
  typedef struct packed {
    logic bc_we;        // Write basic control bits
    logic [3:0] bc;     // Bits 13,12,10,8
    logic bc_keep_sd;   // Keep bits 13 and 8 (mode 111)
    logic adv_we;       // Write advertisement bits
    logic [3:0] adv;    // Bits 8..5
    logic crs_tx;       // Carrier sense also during transmit
    logic repeater;
    logic powerdown;
  } pms_mode_cfg_t;

  // Management read and write strobes with register index and data
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] reg_addr;
    logic [15:0] wdata;
  } pms_mgmt_req_t;
endpackage : pms_pkg

// >>> verif/pms_host_model.sv
// Host management controller model driving the register access port
`timescale 1ns/1ps
`default_nettype none
module pms_host_model (
  // Clock
  input wire logic clk,
  // Register access
  output var pms_pkg::pms_mgmt_req_t req,
  input wire logic [15:0] rdata
);
  // Idle bus at start
  initial begin
    req = '0;
  end

  // One-cycle write strobe, data dropped after the taking edge
  task automatic write(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    req.wr <= 1'b1;
    req.reg_addr <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
    req.wdata <= ~d;  // Released data does not hold
  endtask : write

  // Address held two edges, registered data sampled once settled
  task automatic read(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    req.rd <= 1'b1;
    req.reg_addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    // Registered answer taken one edge after it launched
    @(posedge clk);
    d = rdata;
  endtask : read
endmodule : pms_host_model
`default_nettype wire

// >>> verif/test_phy_mode_and_special_modes_regs.sv
// Testbench for the PHY energy-detect and special-modes registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %0h seen %0h", n, e, g); end end
module test_phy_mode_and_special_modes_regs;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic port_phy_rst = 1'b0;
  logic soft_rst = 1'b0;
  logic an_strap = 1'b1;
  logic spd_strap = 1'b0;
  logic dpx_strap = 1'b1;
  logic [4:0] addr_strap = 5'h0A;
  logic energy_seen = 1'b1;
  logic load_wr = 1'b0;
  logic [15:0] load_data = 16'h0000;
  pms_pkg::pms_mgmt_req_t req;
  logic [15:0] rdata;
  logic edpd_en;
  logic [4:0] phy_addr;
  logic [4:0] seed;
  pms_pkg::pms_mode_cfg_t cfg;
  int err_count = 0;
  int n_compared = 0;
  logic [3:0] bc_tab [8] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hC, 4'hC, 4'h0, 4'hC};
  logic [3:0] msk;
  logic [3:0] amsk;
  logic [4:0] a5;

  // 125 MHz clock
  initial begin
    forever #4 clk = ~clk;
  end

  pms_phy_mode_regs #(.TIMEOUT_CYC(50)) dut (
    .CLK(clk), .RST_B(rst_b), .PORT_PHY_RST(port_phy_rst), .SOFT_RST(soft_rst),
    .AUTONEG_STRAP(an_strap), .SPEED_STRAP(spd_strap), .DUPLEX_STRAP(dpx_strap),
    .ADDR_STRAP(addr_strap), .ENERGY_SEEN(energy_seen), .MGMT_REQ(req),
    .MGMT_RDATA(rdata), .LOAD_WR(load_wr), .LOAD_DATA(load_data),
    .ENERGY_DETECT_POWERDOWN_EN(edpd_en), .PHY_MGMT_ADDRESS(phy_addr),
    .SCRAMBLER_SEED(seed), .MODE_CFG(cfg)
  );

  pms_host_model host (.clk(clk), .req(req), .rdata(rdata));

  // Read a register and compare
  task automatic chk_reg(input string n, input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    host.read(a, d);
    `CHK(n, e, d)
  endtask : chk_reg

  // Hardware reset for 16 cycles, then settle
  task automatic hard_reset();
    rst_b <= 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : hard_reset

  // Counts and verdict
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_sim();
  end

  // Main sequence
  initial begin
    hard_reset();
    an_strap <= 1'b0;
    addr_strap <= 5'h1F;
    chk_reg("pd_reset", pms_pkg::REG_ENERGY_PD, 16'h0002);
    chk_reg("sm_reset", pms_pkg::REG_SPECIAL, 16'h00EA);
    host.write(pms_pkg::REG_ENERGY_PD, 16'hFFFF);
    chk_reg("pd_set", pms_pkg::REG_ENERGY_PD, 16'h2003);
    `CHK("edpd_en", 1'b1, edpd_en)
    host.write(5'h05, 16'hFFFF);
    chk_reg("unmapped", 5'h05, 16'h0000);
    for (int m = 0; m < 8; m++) begin
      a5 = 5'(3 * m + 1);
      host.write(pms_pkg::REG_SPECIAL, {8'hFF, m[2:0], a5});
      repeat (2) @(posedge clk);
      msk = (m == 7) ? 4'h6 : ((m == 6) ? 4'h0 : 4'hF);
      amsk = (m >= 4 && m != 6) ? 4'hF : 4'h0;
      `CHK("bc_we", (m != 6), cfg.bc_we)
      `CHK("bc", bc_tab[m] & msk, cfg.bc & msk)
      `CHK("keep_sd", (m == 7), cfg.bc_keep_sd)
      `CHK("adv_we", (m >= 4 && m != 6), cfg.adv_we)
      `CHK("adv", ((m == 7) ? 4'hF : 4'h4) & amsk, cfg.adv & amsk)
      if (m >= 2 && m <= 5) `CHK("crs_tx", (m == 2 || m == 4), cfg.crs_tx)
      `CHK("repeater", (m == 5), cfg.repeater)
      `CHK("powerdown", (m == 6), cfg.powerdown)
      `CHK("phy_addr", a5, phy_addr)
      `CHK("seed", a5, seed)
      chk_reg("sm_rw", pms_pkg::REG_SPECIAL, {8'h00, m[2:0], a5});
    end
    // Loader and host write in the same cycle
    fork
      host.write(pms_pkg::REG_SPECIAL, 16'h00FF);
      begin
        @(posedge clk);
        load_wr <= 1'b1;
        load_data <= 16'h0061;
        @(posedge clk);
        load_wr <= 1'b0;
        load_data <= 16'hFF9E;
      end
    join
    chk_reg("sm_load", pms_pkg::REG_SPECIAL, 16'h0061);
    soft_rst <= 1'b1;
    repeat (4) @(posedge clk);
    soft_rst <= 1'b0;
    chk_reg("pd_soft", pms_pkg::REG_ENERGY_PD, 16'h2003);
    chk_reg("sm_soft", pms_pkg::REG_SPECIAL, 16'h0061);
    energy_seen <= 1'b0;
    repeat (30) @(posedge clk);
    chk_reg("energy_hold", pms_pkg::REG_ENERGY_PD, 16'h2003);
    repeat (40) @(posedge clk);
    chk_reg("energy_drop", pms_pkg::REG_ENERGY_PD, 16'h2001);
    port_phy_rst <= 1'b1;
    repeat (4) @(posedge clk);
    port_phy_rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk_reg("pd_port", pms_pkg::REG_ENERGY_PD, 16'h0000);
    chk_reg("sm_port", pms_pkg::REG_SPECIAL, 16'h00EA);
    spd_strap <= 1'b1;
    dpx_strap <= 1'b0;
    addr_strap <= 5'h15;
    hard_reset();
    chk_reg("pd_hard", pms_pkg::REG_ENERGY_PD, 16'h0002);
    chk_reg("sm_hard", pms_pkg::REG_SPECIAL, 16'h0055);
    repeat (70) @(posedge clk);
    chk_reg("energy_off", pms_pkg::REG_ENERGY_PD, 16'h0000);
    energy_seen <= 1'b1;
    repeat (4) @(posedge clk);
    chk_reg("energy_on", pms_pkg::REG_ENERGY_PD, 16'h0002);
    end_sim();
  end
endmodule : test_phy_mode_and_special_modes_regs
`default_nettype wire
